// >>> hw/fdi_ctrl.sv
// Flexible-disk drive control interface: pins, step sequencer, write pulser, registers
//
// Added by the designer: strobed register access and the placing of the registers.
`default_nettype none
// Functional notes
// - The direction output is high to move the head away from the spindle and low to move it toward it.
// - The active-low drive select output is low to address the drive and high otherwise.
// - Head side select is low for the lower head and high for the upper head.
// - The active-low motor output is low to run the spindle and high to stop it.
// - Both unit select lines low enable the drive; any other pattern disables it.
// - A low step pulse moves the head one step in the direction set by the direction line.
// - Each low write-flux pulse records one bit, but only while the write gate is low.
// - The write gate is low for the whole recording span and high at all other times.
module fdi_ctrl (
    input wire logic core_clk, // System clock, 20 MHz
    input wire logic resetn, // Async reset, active low
    input wire logic [3:0] reg_addr, // Register word address
    input wire logic [31:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [31:0] reg_rdata, // Read data, cycle after strobe
    output logic irq, // Level interrupt
    output logic dir, // Head direction
    output logic drive_select_n, // Drive select, active low
    output logic unit_sel_lo, // Unit select line 0
    output logic unit_sel_hi, // Unit select line 1
    output logic spindle_motor_on_n, // Motor on, active low
    output logic head_side_select, // Head side
    output logic head_move_pulse_n, // Step pulse, active low
    output logic write_flux_pulse_n, // Write data pulse, active low
    output logic write_enable_window_n, // Write gate, active low
    input wire logic disk_present_n, // Disk inserted, active low
    input wire logic media_changed_n, // Disk change, active low
    input wire logic dense_media_n, // High density, active low
    input wire logic rev_marker_n, // Index pulse, active low
    input wire logic read_flux_pulse_n, // Read data pulse, active low
    input wire logic track_zero_n, // Track 0, active low
    input wire logic media_locked_n // Write protect, active low
);
    import fdi_pkg::*;

    // ********************************************************************
    // State
    // ********************************************************************
    typedef struct packed {
        logic [6:0] sync1;
        logic [6:0] sync2;
        logic [6:0] prev;
        logic [1:0] fill;
        logic sel;
        logic motor;
        logic side;
        logic dirr;
        logic write_enable_window;
        fdi_step_t step_st;
        logic [FDI_CNT_W-1:0] step_cnt;
        logic wpend;
        logic wstop;
        logic [FDI_CNT_W-1:0] w_cnt;
        logic [5:0] stat;
        logic [5:0] inten;
        logic [15:0] flux_cnt;
        logic [31:0] rdata;
        logic irq;
        logic step_n;
        logic wflux_n;
    } fdi_state_t;

    fdi_state_t s_r;
    fdi_state_t s_nxt;

    // Synchronised pin bits: 0 index,1 trk0,2 chg,3 wprot,4 rdata,5 disk,6 dense
    logic [6:0] pins_raw;
    assign pins_raw = {dense_media_n, disk_present_n, read_flux_pulse_n, media_locked_n,
                       media_changed_n, track_zero_n, rev_marker_n};

    logic busy;
    logic [5:0] ev;
    logic [5:0] clr;
    logic locked;
    logic armed;

    always_comb begin
        s_nxt = s_r;
        s_nxt.sync1 = pins_raw;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.prev = s_r.sync2;
        locked = ~s_r.sync2[3];
        // Edges held off until the synchroniser chain has filled
        armed = (s_r.fill == 2'h3);
        if (s_r.fill != 2'h3) begin
            s_nxt.fill = s_r.fill + 2'h1;
        end
        busy = (s_r.step_st != FDI_ST_IDLE) || s_r.write_enable_window;
        ev = 6'h00;
        clr = 6'h00;

        // ****************************************************************
        // Drive events from falling edges of synchronised pins
        // ****************************************************************
        ev[FDI_EV_INDEX] = armed & s_r.prev[0] & ~s_r.sync2[0];
        ev[FDI_EV_TRK0] = armed & s_r.prev[1] & ~s_r.sync2[1];
        ev[FDI_EV_CHG] = armed & s_r.prev[2] & ~s_r.sync2[2];
        ev[FDI_EV_READ] = armed & s_r.prev[4] & ~s_r.sync2[4];
        if (ev[FDI_EV_READ]) begin
            s_nxt.flux_cnt = s_r.flux_cnt + 16'h0001;
        end

        // ****************************************************************
        // Write-protect guard on an active gate
        // ****************************************************************
        if (s_r.write_enable_window && locked) begin
            s_nxt.write_enable_window = 1'b0;
            s_nxt.wpend = 1'b0;
            s_nxt.wstop = 1'b0;
            ev[FDI_EV_WPERR] = 1'b1;
        end

        // ****************************************************************
        // Step sequencer
        // ****************************************************************
        case (s_r.step_st)
            FDI_ST_IDLE: begin
                s_nxt.step_n = 1'b1;
            end
            FDI_ST_STEP_LOW: begin
                if (s_r.step_cnt == FDI_CNT_W'(1)) begin
                    s_nxt.step_n = 1'b1;
                    s_nxt.step_cnt = FDI_CNT_W'(FDI_STEP_SETTLE_CYC);
                    s_nxt.step_st = FDI_ST_STEP_SETTLE;
                end else begin
                    s_nxt.step_cnt = s_r.step_cnt - FDI_CNT_W'(1);
                end
            end
            FDI_ST_STEP_SETTLE: begin
                if (s_r.step_cnt == FDI_CNT_W'(1)) begin
                    s_nxt.step_st = FDI_ST_IDLE;
                    ev[FDI_EV_STEPDONE] = 1'b1;
                end else begin
                    s_nxt.step_cnt = s_r.step_cnt - FDI_CNT_W'(1);
                end
            end
            default: begin
                s_nxt.step_st = FDI_ST_IDLE;
            end
        endcase

        // ****************************************************************
        // Write flux pulser
        // ****************************************************************
        if (s_r.w_cnt != FDI_CNT_W'(0)) begin
            s_nxt.w_cnt = s_r.w_cnt - FDI_CNT_W'(1);
            if (s_r.w_cnt == FDI_CNT_W'(1)) begin
                s_nxt.wflux_n = 1'b1;
            end
        end else if (s_r.wpend && s_r.write_enable_window && !locked) begin
            s_nxt.wflux_n = 1'b0;
            s_nxt.wpend = 1'b0;
            s_nxt.w_cnt = FDI_CNT_W'(FDI_WPULSE_CYC);
        end

        // ****************************************************************
        // Register writes
        // ****************************************************************
        if (reg_wr) begin
            if (reg_addr == FDI_CTRL_OFS) begin
                s_nxt.sel = reg_wdata[FDI_CTRL_SEL_BIT];
                s_nxt.motor = reg_wdata[FDI_CTRL_MOTOR_BIT];
                if (!busy) begin
                    s_nxt.side = reg_wdata[FDI_CTRL_SIDE_BIT];
                    s_nxt.dirr = reg_wdata[FDI_CTRL_DIR_BIT];
                end
                if (reg_wdata[FDI_CTRL_WRITE_BIT]) begin
                    s_nxt.wstop = 1'b0;
                    if (!s_r.write_enable_window) begin
                        if (locked) begin
                            ev[FDI_EV_WPERR] = 1'b1;
                        end else if (s_r.step_st == FDI_ST_IDLE) begin
                            s_nxt.write_enable_window = 1'b1;
                        end
                    end
                end else if (s_r.write_enable_window) begin
                    // Close waits for a pending or running pulse
                    s_nxt.wstop = 1'b1;
                end
            end else if (reg_addr == FDI_STEP_OFS) begin
                if (s_r.step_st == FDI_ST_IDLE && !s_r.write_enable_window) begin
                    s_nxt.step_n = 1'b0;
                    s_nxt.step_st = FDI_ST_STEP_LOW;
                    s_nxt.step_cnt = FDI_CNT_W'(FDI_STEP_LOW_CYC);
                end
            end else if (reg_addr == FDI_WDATA_OFS) begin
                if (s_r.write_enable_window && !locked) begin
                    s_nxt.wpend = 1'b1;
                end
            end else if (reg_addr == FDI_INTEN_OFS) begin
                s_nxt.inten = reg_wdata[5:0];
            end else if (reg_addr == FDI_INTCLR_OFS) begin
                clr = reg_wdata[5:0];
            end
        end

        if (s_nxt.wstop && s_nxt.w_cnt == FDI_CNT_W'(0) && !s_nxt.wpend) begin
            s_nxt.write_enable_window = 1'b0;
            s_nxt.wstop = 1'b0;
        end

        // Set wins over clear
        s_nxt.stat = (s_r.stat & ~clr) | ev;
        s_nxt.irq = |(s_nxt.stat & s_nxt.inten);

        // ****************************************************************
        // Register reads
        // ****************************************************************
        s_nxt.rdata = 32'h0000_0000;
        if (reg_rd) begin
            if (reg_addr == FDI_CTRL_OFS) begin
                s_nxt.rdata = {27'h0, s_r.write_enable_window, s_r.dirr, s_r.side, s_r.motor, s_r.sel};
            end else if (reg_addr == FDI_STEP_OFS) begin
                s_nxt.rdata = {30'h0, s_r.wpend, (s_r.step_st != FDI_ST_IDLE)};
            end else if (reg_addr == FDI_PINS_OFS) begin
                s_nxt.rdata = {25'h0, ~s_r.sync2};
            end else if (reg_addr == FDI_STAT_OFS) begin
                s_nxt.rdata = {26'h0, s_r.stat};
            end else if (reg_addr == FDI_INTEN_OFS) begin
                s_nxt.rdata = {26'h0, s_r.inten};
            end else if (reg_addr == FDI_FLUXCNT_OFS) begin
                s_nxt.rdata = {16'h0, s_r.flux_cnt};
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '{sync1: 7'h7f, sync2: 7'h7f, prev: 7'h7f, fill: 2'h0, sel: 1'b0, motor: 1'b0,
                     side: 1'b0, dirr: 1'b0, write_enable_window: 1'b0, step_st: FDI_ST_IDLE,
                     step_cnt: 8'h00, wpend: 1'b0, wstop: 1'b0, w_cnt: 8'h00, stat: FDI_EV_RST,
                     inten: 6'h00, flux_cnt: 16'h0000, rdata: 32'h0000_0000,
                     irq: 1'b0, step_n: 1'b1, wflux_n: 1'b1};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ********************************************************************
    // Pin drivers, all from flip-flops
    // ********************************************************************
    assign reg_rdata = s_r.rdata;
    assign irq = s_r.irq;
    assign dir = s_r.dirr;
    assign drive_select_n = ~s_r.sel;
    assign unit_sel_lo = ~s_r.sel;
    assign unit_sel_hi = ~s_r.sel;
    assign spindle_motor_on_n = ~s_r.motor;
    assign head_side_select = s_r.side;
    assign head_move_pulse_n = s_r.step_n;
    assign write_flux_pulse_n = s_r.wflux_n;
    assign write_enable_window_n = ~s_r.write_enable_window;
endmodule
`default_nettype wire

// >>> include/fdi_pkg.sv
// Constants and types for the flexible-disk drive control interface
`default_nettype none
package fdi_pkg;
    // ********************************************************************
    // Register map (word offsets on the plain register port)
    // ********************************************************************
    localparam logic [3:0] FDI_CTRL_OFS = 4'h0;
    localparam logic [3:0] FDI_STEP_OFS = 4'h1;
    localparam logic [3:0] FDI_WDATA_OFS = 4'h2;
    localparam logic [3:0] FDI_PINS_OFS = 4'h3;
    localparam logic [3:0] FDI_STAT_OFS = 4'h4;
    localparam logic [3:0] FDI_INTEN_OFS = 4'h5;
    localparam logic [3:0] FDI_INTCLR_OFS = 4'h6;
    localparam logic [3:0] FDI_FLUXCNT_OFS = 4'h7;

    // ********************************************************************
    // Control register fields
    // ********************************************************************
    localparam int FDI_CTRL_SEL_BIT = 0;
    localparam int FDI_CTRL_MOTOR_BIT = 1;
    localparam int FDI_CTRL_SIDE_BIT = 2;
    localparam int FDI_CTRL_DIR_BIT = 3;
    localparam int FDI_CTRL_WRITE_BIT = 4;
    localparam logic [4:0] FDI_CTRL_RST = 5'h00;

    // ********************************************************************
    // Status / interrupt fields
    // ********************************************************************
    localparam int FDI_EV_INDEX = 0;
    localparam int FDI_EV_TRK0 = 1;
    localparam int FDI_EV_CHG = 2;
    localparam int FDI_EV_WPERR = 3;
    localparam int FDI_EV_STEPDONE = 4;
    localparam int FDI_EV_READ = 5;
    localparam int FDI_EV_W = 6;
    localparam logic [5:0] FDI_EV_RST = 6'h00;

    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int FDI_CLK_NS = 50;
    localparam int FDI_STEP_LOW_NS = 1000;
    localparam int FDI_STEP_SETTLE_NS = 1000;
    localparam int FDI_WPULSE_NS = 250;
    localparam int FDI_STEP_LOW_CYC = (FDI_STEP_LOW_NS + FDI_CLK_NS - 1) / FDI_CLK_NS;
    localparam int FDI_STEP_SETTLE_CYC = (FDI_STEP_SETTLE_NS + FDI_CLK_NS - 1) / FDI_CLK_NS;
    localparam int FDI_WPULSE_CYC = (FDI_WPULSE_NS + FDI_CLK_NS - 1) / FDI_CLK_NS;
    localparam int FDI_CNT_W = 8;

    typedef enum logic [1:0] {
        FDI_ST_IDLE,
        FDI_ST_STEP_LOW,
        FDI_ST_STEP_SETTLE
    } fdi_step_t;
endpackage
`default_nettype wire

// >>> verification/fdi_ctrl_assertions.sv
// Port checks for the drive control interface
`default_nettype none
module fdi_ctrl_assertions (
    input wire logic core_clk, // Clock
    input wire logic resetn, // Reset, active low
    input wire logic [3:0] reg_addr, // Address
    input wire logic [31:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [31:0] reg_rdata, // Read data
    input wire logic dir, // Direction
    input wire logic drive_select_n, // Select
    input wire logic unit_sel_lo, // Unit line 0
    input wire logic unit_sel_hi, // Unit line 1
    input wire logic spindle_motor_on_n, // Motor
    input wire logic head_side_select, // Side
    input wire logic head_move_pulse_n, // Step
    input wire logic write_flux_pulse_n, // Write pulse
    input wire logic write_enable_window_n, // Gate
    input wire logic media_locked_n // Protect
);
    timeunit 1ns;
    timeprecision 1ns;
    import fdi_pkg::*;
    // ****
    // Checks
    // ****
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_sel_lines: assert property (drive_select_n == unit_sel_lo && unit_sel_lo == unit_sel_hi)
        else $error("Select lines disagree");
    a_motor_ctrl: assert property (reg_wr && reg_addr == FDI_CTRL_OFS |-> ##2
        spindle_motor_on_n == !$past(reg_wdata[1], 2)) else $error("Motor does not follow control");
    a_step_width: assert property ($fell(head_move_pulse_n) |-> ##19 !head_move_pulse_n ##1 head_move_pulse_n)
        else $error("Step pulse width wrong");
    a_wflux_width: assert property ($fell(write_flux_pulse_n) |-> !write_flux_pulse_n [*5] ##1 write_flux_pulse_n)
        else $error("Write pulse width wrong");
    a_wflux_gated: assert property (!write_flux_pulse_n |-> !write_enable_window_n)
        else $error("Write pulse outside gate");
    a_head_rest: assert property (!$stable(dir) || !$stable(head_side_select) |->
        $past(head_move_pulse_n) && $past(write_enable_window_n)) else $error("Head changed while busy");
    a_gate_locked: assert property (!media_locked_n [*8] |-> write_enable_window_n)
        else $error("Gate open on locked media");
    a_gate_off: assert property (reg_wr && reg_addr == FDI_CTRL_OFS && !reg_wdata[4] |-> ##8 write_enable_window_n)
        else $error("Gate stays open");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("Read data not idle");
    c_step: cover property ($fell(head_move_pulse_n));
    c_write: cover property ($fell(write_flux_pulse_n));
    c_refuse: cover property (!media_locked_n && reg_wr && reg_wdata[4]);
endmodule
bind fdi_ctrl fdi_ctrl_assertions u_chk (.*);
`default_nettype wire

// >>> verification/fdi_ctrl_tb.sv
// Self-checking bench for the drive control interface
`default_nettype none
module fdi_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import fdi_pkg::*;
    logic core_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, disk_in = 1'b1, dense = 1'b1, locked = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
    logic irq, dir, drive_select_n, unit_sel_lo, unit_sel_hi, spindle_motor_on_n, head_side_select;
    logic head_move_pulse_n, write_flux_pulse_n, write_enable_window_n, disk_present_n, media_changed_n;
    logic dense_media_n, rev_marker_n, read_flux_pulse_n, track_zero_n, media_locked_n;
    int track, wr_bits, bad_count = 0, checked = 0;
    fdi_ctrl u_dut (.*);
    fdi_drive_model u_drv (.*);
    always #25 core_clk = ~core_clk;
    // ****
    // Bus and check tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d errors %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic wait_stat(input int b);
        for (int i = 0; i < 2000; i++) begin
            rd(FDI_STAT_OFS);
            if (d[b] === 1'b1) return;
        end
        chk(d, 32'(1) << b);
        tally_and_finish();
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_reset();
        @(negedge core_clk);
        chk(32'({drive_select_n, unit_sel_lo, unit_sel_hi, spindle_motor_on_n}), 32'hf);
        chk(32'({dir, head_side_select, head_move_pulse_n, write_flux_pulse_n, write_enable_window_n, irq}), 32'he);
        rd(4'hf);
        chk(d, 32'h0);
        rd(FDI_STAT_OFS);
        chk(d, 32'h0);
    endtask
    task automatic t_ctrl();
        wr(FDI_CTRL_OFS, 32'h0f);
        idle(1);
        chk(32'({drive_select_n, unit_sel_lo, unit_sel_hi, spindle_motor_on_n, head_side_select, dir}), 32'h3);
        wr(FDI_CTRL_OFS, 32'h03);
        idle(1);
        chk(32'({head_side_select, dir}), 32'h0);
    endtask
    task automatic t_step();
        wr(FDI_INTEN_OFS, 32'h10);
        wr(FDI_STEP_OFS, 32'h1);
        wr(FDI_STEP_OFS, 32'h1);
        wr(FDI_CTRL_OFS, 32'h0b);
        rd(FDI_STEP_OFS);
        chk(32'(d[0]), 32'h1);
        wait_stat(FDI_EV_STEPDONE);
        chk(32'({irq, dir, track_zero_n}), 32'h5);
        chk(track, 1);
        wr(FDI_INTCLR_OFS, 32'h10);
        idle(2);
        chk(32'(irq), 32'h0);
        wr(FDI_CTRL_OFS, 32'h0b);
        wr(FDI_STEP_OFS, 32'h1);
        wait_stat(FDI_EV_STEPDONE);
        rd(FDI_PINS_OFS);
        chk(32'({d[1], dir, track_zero_n}), 32'h6);
        wr(FDI_INTCLR_OFS, 32'h3f);
    endtask
    task automatic t_media();
        disk_in <= 1'b0;
        idle(8);
        rd(FDI_PINS_OFS);
        chk(32'({d[6:5], d[2]}), 32'h1);
        rd(FDI_STAT_OFS);
        chk(32'(d[FDI_EV_CHG]), 32'h1);
        disk_in <= 1'b1;
        idle(8);
        wr(FDI_STEP_OFS, 32'h1);
        idle(50);
        rd(FDI_PINS_OFS);
        chk(32'({d[6:5], d[2]}), 32'h6);
    endtask
    task automatic t_write();
        locked <= 1'b1;
        idle(8);
        wr(FDI_CTRL_OFS, 32'h1b);
        idle(4);
        chk(32'(write_enable_window_n), 32'h1);
        rd(FDI_STAT_OFS);
        chk(32'(d[FDI_EV_WPERR]), 32'h1);
        locked <= 1'b0;
        wr(FDI_CTRL_OFS, 32'h0b);
        idle(8);
        wr(FDI_CTRL_OFS, 32'h1b);
        idle(1);
        chk(32'(write_enable_window_n), 32'h0);
        wr(FDI_WDATA_OFS, 32'h1);
        idle(10);
        wr(FDI_WDATA_OFS, 32'h1);
        wr(FDI_CTRL_OFS, 32'h0b);
        idle(0);
        chk(32'(write_enable_window_n), 32'h0);
        idle(8);
        chk(32'(write_enable_window_n), 32'h1);
        wr(FDI_WDATA_OFS, 32'h1);
        idle(10);
        chk(wr_bits, 2);
    endtask
    task automatic t_index();
        logic [31:0] first;
        wr(FDI_INTCLR_OFS, 32'h3f);
        wait_stat(FDI_EV_INDEX);
        wait_stat(FDI_EV_READ);
        rd(FDI_FLUXCNT_OFS);
        chk(32'(d != 32'h0), 32'h1);
        first = d;
        // Flux pulses repeat every 16 cycles; the two samples are 160 cycles apart
        idle(158);
        rd(FDI_FLUXCNT_OFS);
        chk(d - first, 32'h0000_000a);
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset();
        t_ctrl();
        t_step();
        t_media();
        t_write();
        t_index();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// >>> verification/fdi_drive_model.sv
// Behavioural flexible-disk drive facing the interface
`default_nettype none
module fdi_drive_model (
    input wire logic dir, // Direction
    input wire logic drive_select_n, // Select
    input wire logic unit_sel_lo, // Unit line 0
    input wire logic unit_sel_hi, // Unit line 1
    input wire logic spindle_motor_on_n, // Motor
    input wire logic head_move_pulse_n, // Step
    input wire logic write_flux_pulse_n, // Write pulse
    input wire logic write_enable_window_n, // Gate
    input wire logic disk_in, // Disk inserted
    input wire logic dense, // High-density disk
    input wire logic locked, // Protected disk
    output logic disk_present_n, // Present
    output logic media_changed_n, // Changed
    output logic dense_media_n, // Dense
    output logic rev_marker_n, // Index
    output logic read_flux_pulse_n, // Read pulse
    output logic track_zero_n, // Track 0
    output logic media_locked_n, // Protect
    output int track, // Head track
    output int wr_bits // Bits written
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // Drive behaviour
    // ****
    int tick = 0;
    logic chg = 1'b1;
    wire logic sel = !drive_select_n && !unit_sel_lo && !unit_sel_hi;
    wire logic run = sel && !spindle_motor_on_n && disk_in;
    initial track = 0;
    initial wr_bits = 0;
    always #50 tick++;
    assign disk_present_n = !disk_in;
    assign dense_media_n = !(disk_in && dense);
    assign media_locked_n = !(disk_in && locked);
    assign track_zero_n = track != 0;
    assign media_changed_n = chg;
    assign rev_marker_n = !(run && tick % 200 < 4);
    assign read_flux_pulse_n = !(run && tick % 16 < 3);
    always @(negedge disk_in) chg = 1'b0;
    always @(negedge head_move_pulse_n) begin
        if (sel) begin
            chg = chg | disk_in;
            track = dir ? (track == 0 ? 0 : track - 1) : track + 1;
        end
    end
    always @(negedge write_flux_pulse_n) if (sel && !write_enable_window_n) wr_bits++;
endmodule
`default_nettype wire
